/* include/cbtr_pkg.sv */
// package: constants and carriers for the can bit timing and register access block
package cbtr_pkg;
   // ----------------------------------------------------------------
   // indirect register indices
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_CONTROL    = 8'h00;
   localparam logic [7:0]  IDX_STATUS     = 8'h01;
   localparam logic [7:0]  IDX_ERROR      = 8'h02;
   localparam logic [7:0]  IDX_BIT_TIMING = 8'h03;
   localparam logic [7:0]  IDX_INTERRUPT  = 8'h04;
   localparam logic [7:0]  IDX_TEST       = 8'h05;
   localparam logic [7:0]  IDX_PRESCALER  = 8'h06;
   localparam logic [7:0]  IDX_SET1_FIRST = 8'h08;
   localparam logic [7:0]  IDX_SET1_LAST  = 8'h12;
   localparam logic [7:0]  IDX_SET2_FIRST = 8'h20;
   localparam logic [7:0]  IDX_SET2_LAST  = 8'h2A;
   localparam logic [7:0]  IDX_TXREQ_1    = 8'h40;
   localparam logic [7:0]  IDX_TXREQ_2    = 8'h41;
   localparam logic [7:0]  IDX_NEWDAT_1   = 8'h48;
   localparam logic [7:0]  IDX_NEWDAT_2   = 8'h49;
   localparam logic [7:0]  IDX_INTPND_1   = 8'h50;
   localparam logic [7:0]  IDX_INTPND_2   = 8'h51;
   localparam logic [7:0]  IDX_MSGVAL_1   = 8'h58;
   localparam logic [7:0]  IDX_MSGVAL_2   = 8'h59;
   localparam logic [7:0]  IF_WORDS       = 8'h0B;
   // ----------------------------------------------------------------
   // direct port selects
   // ----------------------------------------------------------------
   localparam logic [2:0]  SEL_CONTROL    = 3'h0;
   localparam logic [2:0]  SEL_STATUS     = 3'h1;
   localparam logic [2:0]  SEL_TEST       = 3'h2;
   localparam logic [2:0]  SEL_INDEX      = 3'h3;
   localparam logic [2:0]  SEL_DATA_HIGH  = 3'h4;
   localparam logic [2:0]  SEL_DATA_LOW   = 3'h5;
   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int          CTL_INIT_BIT   = 0;
   localparam int          CTL_CHGEN_BIT  = 6;
   localparam int          CTL_TEST_BIT   = 7;
   localparam logic [15:0] CONTROL_RESET  = 16'h0001;
   localparam logic [15:0] TIMING_RESET   = 16'h2301;
   localparam logic [15:0] PRESC_RESET    = 16'h0000;
   localparam logic [15:0] MASK_RESET     = 16'hFFFF;
   localparam logic [15:0] CMDREQ_RESET   = 16'h0001;
   localparam int          PH2_LSB        = 12;
   localparam int          SEG1_LSB       = 8;
   localparam int          JUMP_LSB       = 6;
   localparam int          CMDREQ_BUSY    = 15;
   localparam int          CMDMASK_WRITE  = 7;
   localparam int          OBJ_COUNT      = 32;
   localparam int          OBJ_WORDS      = 9;

   typedef struct packed {
      logic [2:0] ph2;
      logic [3:0] seg1;
      logic [1:0] jump;
      logic [5:0] presc_lo;
      logic [3:0] presc_ext;
   } cbtr_timing_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] sel;
      logic [7:0] data;
   } cbtr_access_s;

   typedef enum logic [3:0] {
      SEG_SYNC  = 4'b0001,
      SEG_PROP  = 4'b0010,
      SEG_PH2   = 4'b0100,
      SEG_IDLE  = 4'b1000
   } cbtr_seg_e;
endpackage : cbtr_pkg

/* verilog/cbtr_core.sv */
// design: can bit timing, indirect register access and message ram interface
//
// What this block does
// - protocol timing runs from a clock derived from the core system clock.
// - effective prescaler is prescaler extension over the timing word's low prescaler bits, plus one; resets to two.
// - one time quantum is clock period times effective prescaler.
// - a bit is sync, prop, phase1, phase2 segments of whole quanta.
// - timing word packs phase2, first segment, jump width, prescaler low.
// - each timing field holds its length minus one.
// - control, status, test reachable directly and indirectly; others only indirectly.
// - writing an object number to command request moves interface set data.
// - two independent interface register sets exist.
// - message handler registers are read only per-object flag words.
// - timing word writes only with change enable set; resets to 2301.
// - prescaler extension writes only while the test bit is set.
// - index in interface ranges advances by one after each low data access, except at the last word of a range.
`timescale 1ns/1ps
`default_nettype none
module cbtr_core (
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_i,
   input  wire cbtr_pkg::cbtr_access_s acc_i,
   input  wire logic                 edge_i,
   input  wire logic [31:0]          obj_txreq_i,
   input  wire logic [31:0]          obj_newdat_i,
   input  wire logic [31:0]          obj_intpnd_i,
   output logic      [7:0]           rdata_o,
   output logic                      in_init_o,
   output logic                      sample_o,
   output logic                      bit_start_o
);
   import cbtr_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [15:0] control_reg, status_reg, test_reg;
   logic [15:0] timing_reg, presc_reg;
   logic [7:0]  index_reg;
   logic [7:0]  high_hold_reg;
   logic [15:0] if_reg [2][11];
   logic [15:0] ram [OBJ_COUNT][OBJ_WORDS];
   logic [31:0] valid_reg;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire         wr_ctl   = acc_i.wr && acc_i.sel == SEL_CONTROL;
   wire         wr_tst   = acc_i.wr && acc_i.sel == SEL_TEST;
   wire         wr_idx   = acc_i.wr && acc_i.sel == SEL_INDEX;
   wire         wr_high  = acc_i.wr && acc_i.sel == SEL_DATA_HIGH;
   wire         low_acc  = (acc_i.wr || acc_i.rd) && acc_i.sel == SEL_DATA_LOW;
   wire         wr_low   = acc_i.wr && acc_i.sel == SEL_DATA_LOW;
   wire [15:0]  wword    = {high_hold_reg, acc_i.data};
   wire         in_set1  = index_reg >= IDX_SET1_FIRST && index_reg <= IDX_SET1_LAST;
   wire         in_set2  = index_reg >= IDX_SET2_FIRST && index_reg <= IDX_SET2_LAST;
   wire         if_sel   = in_set2;
   wire [3:0]   if_off   = in_set2 ? 4'(index_reg - IDX_SET2_FIRST)
                                   : 4'(index_reg - IDX_SET1_FIRST);
   wire         chg_en   = control_reg[CTL_CHGEN_BIT];
   wire         testen   = control_reg[CTL_TEST_BIT];

   // indexed read word; handler flags are read only
   logic [15:0] iword;
   always_comb begin
      iword = 16'h0000;
      if (in_set1 || in_set2) begin
         iword = if_reg[if_sel][if_off];
      end else begin
         case (index_reg)
            IDX_CONTROL:    iword = control_reg;
            IDX_STATUS:     iword = status_reg;
            IDX_TEST:       iword = test_reg;
            IDX_BIT_TIMING: iword = timing_reg;
            IDX_PRESCALER:  iword = presc_reg;
            IDX_TXREQ_1:    iword = obj_txreq_i[15:0];
            IDX_TXREQ_2:    iword = obj_txreq_i[31:16];
            IDX_NEWDAT_1:   iword = obj_newdat_i[15:0];
            IDX_NEWDAT_2:   iword = obj_newdat_i[31:16];
            IDX_INTPND_1:   iword = obj_intpnd_i[15:0];
            IDX_INTPND_2:   iword = obj_intpnd_i[31:16];
            IDX_MSGVAL_1:   iword = valid_reg[15:0];
            IDX_MSGVAL_2:   iword = valid_reg[31:16];
            default:        iword = 16'h0000;
         endcase
      end
   end

   // direct read mux
   logic [7:0] rmux;
   always_comb begin
      case (acc_i.sel)
         SEL_CONTROL:   rmux = control_reg[7:0];
         SEL_STATUS:    rmux = status_reg[7:0];
         SEL_TEST:      rmux = test_reg[7:0];
         SEL_INDEX:     rmux = index_reg;
         SEL_DATA_HIGH: rmux = iword[15:8];
         SEL_DATA_LOW:  rmux = iword[7:0];
         default:       rmux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   wire         ix_ctl   = wr_low && index_reg == IDX_CONTROL;
   wire         ix_tst   = wr_low && index_reg == IDX_TEST;
   wire         wr_if    = wr_low && (in_set1 || in_set2);
   wire [4:0]   obj_num  = 5'(wword[4:0] - 5'h01);
   wire         cmd_go   = wr_if && if_off == 4'h0 && wword[5:0] != 6'h00
                           && wword[5:0] <= 6'(OBJ_COUNT);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         control_reg   <= CONTROL_RESET;
         status_reg    <= 16'h0000;
         test_reg      <= 16'h0000;
         timing_reg    <= TIMING_RESET;
         presc_reg     <= PRESC_RESET;
         index_reg     <= 8'h00;
         high_hold_reg <= 8'h00;
         valid_reg     <= 32'h0000_0000;
         rdata_o       <= 8'h00;
      end else begin
         rdata_o <= rmux;
         if (wr_ctl) control_reg[7:0] <= acc_i.data;
         else if (ix_ctl) control_reg <= wword;
         if (wr_tst) test_reg[7:0] <= acc_i.data;
         else if (ix_tst) test_reg <= wword;
         if (wr_high) high_hold_reg <= acc_i.data;
         if (wr_low && index_reg == IDX_BIT_TIMING && chg_en) timing_reg <= wword;
         if (wr_low && index_reg == IDX_PRESCALER && testen)
            presc_reg <= {12'h000, wword[3:0]};
         if (wr_idx) index_reg <= acc_i.data;
         else if (low_acc && (in_set1 || in_set2)
                  && index_reg != IDX_SET1_LAST && index_reg != IDX_SET2_LAST)
            index_reg <= 8'(index_reg + 8'h01);
         if (cmd_go && if_reg[if_sel][1][CMDMASK_WRITE])
            valid_reg[obj_num] <= if_reg[if_sel][6][15];
      end
   end

   // interface sets and message ram transfer
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int s = 0; s < 2; s++) begin
            for (int w = 0; w < 11; w++) begin
               if_reg[s][w] <= (w == 2 || w == 3) ? MASK_RESET
                             : (w == 0) ? CMDREQ_RESET : 16'h0000;
            end
         end
      end else if (cmd_go) begin
         if_reg[if_sel][0] <= wword;
         for (int w = 0; w < OBJ_WORDS; w++) begin
            if (if_reg[if_sel][1][CMDMASK_WRITE])
               ram[obj_num][w] <= if_reg[if_sel][w + 2];
            else
               if_reg[if_sel][w + 2] <= ram[obj_num][w];
         end
      end else if (wr_if) begin
         if_reg[if_sel][if_off] <= wword;
      end
   end

   // ----------------------------------------------------------------
   // bit timing engine
   // ----------------------------------------------------------------
   // fields hold length minus one
   wire [5:0]  plo_f  = timing_reg[5:0];
   wire [1:0]  jump_f = timing_reg[7:JUMP_LSB];
   wire [3:0]  seg1_f = timing_reg[11:SEG1_LSB];
   wire [2:0]  ph2_f  = timing_reg[14:PH2_LSB];
   wire [9:0]  presc  = {presc_reg[3:0], plo_f};
   logic [9:0] pre_cnt_reg;
   logic [4:0] seg_cnt_reg;
   cbtr_seg_e  seg_reg;
   logic       resync_done_reg;
   wire        tq_en  = pre_cnt_reg == presc;
   wire [4:0]  jump_l = {3'h0, jump_f} + 5'h01;
   wire [4:0]  ph2_l  = {2'h0, ph2_f} + 5'h01;
   wire [4:0]  t1_l   = {1'h0, seg1_f} + 5'h01;
   // resync shift limited to the jump width plus one quantum
   // one late resync per bit, else a noisy bus could stretch a bit forever
   wire        early  = edge_i && seg_reg == SEG_PH2;
   wire        late   = edge_i && seg_reg == SEG_PROP && !resync_done_reg;

   assign in_init_o = control_reg[CTL_INIT_BIT];

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || in_init_o) begin
         pre_cnt_reg <= 10'h000;
         seg_cnt_reg <= 5'h00;
         seg_reg     <= SEG_IDLE;
         resync_done_reg <= 1'b0;
         sample_o    <= 1'b0;
         bit_start_o <= 1'b0;
      end else begin
         sample_o    <= 1'b0;
         bit_start_o <= 1'b0;
         pre_cnt_reg <= tq_en ? 10'h000 : 10'(pre_cnt_reg + 10'h001);
         if (tq_en && late) resync_done_reg <= 1'b1;
         if (tq_en) begin
            case (seg_reg)
               SEG_SYNC: begin
                  seg_reg     <= SEG_PROP;
                  resync_done_reg <= 1'b0;
                  seg_cnt_reg <= 5'h00;
               end
               SEG_PROP: begin
                  if (late && seg_cnt_reg >= jump_l) seg_cnt_reg <= 5'(seg_cnt_reg - jump_l);
                  else if (late) seg_cnt_reg <= 5'h00;
                  else if (seg_cnt_reg + 5'h01 >= t1_l) begin
                     seg_reg     <= SEG_PH2;
                     seg_cnt_reg <= 5'h00;
                     sample_o    <= 1'b1;
                  end else seg_cnt_reg <= 5'(seg_cnt_reg + 5'h01);
               end
               SEG_PH2: begin
                  if (seg_cnt_reg + 5'h01 >= ph2_l
                      || (early && ph2_l - seg_cnt_reg <= jump_l)) begin
                     seg_reg     <= SEG_SYNC;
                     bit_start_o <= 1'b1;
                  end else seg_cnt_reg <= 5'(seg_cnt_reg + 5'h01);
               end
               SEG_IDLE: begin
                  seg_reg     <= SEG_SYNC;
                  bit_start_o <= 1'b1;
               end
               default: seg_reg <= SEG_IDLE;
            endcase
         end
      end
   end
endmodule : cbtr_core
`default_nettype wire

/* sim/cbtr_monitor.sv */
// checker: port properties of the can bit timing core
`timescale 1ns/1ps
`default_nettype none
module cbtr_monitor (
   input wire logic                   sys_clk_i,
   input wire logic                   rst_i,
   input wire cbtr_pkg::cbtr_access_s acc_i,
   input wire logic                   edge_i,
   input wire logic [7:0]             rdata_o,
   input wire logic                   in_init_o,
   input wire logic                   sample_o,
   input wire logic                   bit_start_o
);
   import cbtr_pkg::*;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_reset;
      disable iff (1'b0) rst_i |=> rdata_o == 8'h00 && in_init_o && !sample_o && !bit_start_o;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_init_idle;
      in_init_o && $past(in_init_o) |-> !bit_start_o && !sample_o;
   endproperty
   a_init_idle: assert property (p_init_idle) else $error("bit timing ran in init");
   property p_init_write;
      acc_i.wr && acc_i.sel == SEL_CONTROL |=> in_init_o == $past(acc_i.data[CTL_INIT_BIT]);
   endproperty
   a_init_write: assert property (p_init_write) else $error("init bit not written");
   property p_index_rb;
      acc_i.wr && acc_i.sel == SEL_INDEX ##1 acc_i.sel == SEL_INDEX && !acc_i.wr
         |=> rdata_o == $past(acc_i.data, 2);
   endproperty
   a_index_rb: assert property (p_index_rb) else $error("index readback wrong");
   property p_start_gap;
      bit_start_o |=> !bit_start_o [*2];
   endproperty
   a_start_gap: assert property (p_start_gap) else $error("bit start too close");
   property p_sample_gap;
      sample_o |=> !sample_o [*2];
   endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("sample too close");
   property p_not_both;
      sample_o |-> !bit_start_o;
   endproperty
   a_not_both: assert property (p_not_both) else $error("sample at bit start");
   // bound: 29 quanta of 1024 clocks; a bit with one full resync can reach 30
   logic [15:0] quiet_cnt;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || in_init_o || bit_start_o) quiet_cnt <= 16'h0000;
      else if (quiet_cnt != 16'hFFFF) quiet_cnt <= 16'(quiet_cnt + 16'h0001);
   end
   property p_run;
      !in_init_o |-> quiet_cnt <= 16'h7400;
   endproperty
   a_run: assert property (p_run) else $error("no bit after init left");
   c_bit: cover property (bit_start_o);
   c_sample: cover property (sample_o);
   c_run: cover property ($fell(in_init_o));
endmodule : cbtr_monitor
`default_nettype wire

/* sim/cbtr_bus_model.sv */
// model: bus side of the controller, object flags and bus edges
`timescale 1ns/1ps
`default_nettype none
module cbtr_bus_model (
   input  wire logic        sys_clk_i,
   input  wire logic        edge_req_i,
   input  wire logic [95:0] flags_i,
   output logic             edge_o,
   output logic [31:0]      txreq_o,
   output logic [31:0]      newdat_o,
   output logic [31:0]      intpnd_o
);
   // an edge follows the request one clock later and lasts as long as the request does
   always_ff @(posedge sys_clk_i) begin
      edge_o <= edge_req_i;
      {txreq_o, newdat_o, intpnd_o} <= flags_i;
   end
endmodule : cbtr_bus_model
`default_nettype wire

/* sim/tb.sv */
// bench: register access and bit timing of the core
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cbtr_pkg::*;
   logic sys_clk_i, rst_i, edge_req, edge_w, in_init, smp, bst, rd_pend;
   cbtr_access_s acc;
   logic [95:0]  flags;
   logic [31:0]  txr, ndt, ipd, seed;
   logic [7:0]   rdata;
   logic [7:0]   expq[$];
   int           fails, total_checks, cyc, t0, t1, t2;
   localparam int SHIFT[6] = '{64, 80, 32, 48, 0, 16};
   localparam logic [7:0] HIDX[6] = '{IDX_TXREQ_1, IDX_TXREQ_2, IDX_NEWDAT_1,
      IDX_NEWDAT_2, IDX_INTPND_1, IDX_INTPND_2};
   cbtr_core u_cbtr_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .acc_i(acc), .edge_i(edge_w),
      .obj_txreq_i(txr), .obj_newdat_i(ndt), .obj_intpnd_i(ipd), .rdata_o(rdata),
      .in_init_o(in_init), .sample_o(smp), .bit_start_o(bst));
   cbtr_bus_model u_cbtr_bus_model (.sys_clk_i(sys_clk_i), .edge_req_i(edge_req),
      .flags_i(flags), .edge_o(edge_w), .txreq_o(txr), .newdat_o(ndt), .intpnd_o(ipd));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic stop_test();
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic op(input logic w, input logic [2:0] s, input logic [7:0] d);
      @(posedge sys_clk_i);
      acc <= '{wr: w, rd: !w, sel: s, data: d};
   endtask : op
   task automatic rd(input logic [2:0] s, input logic [7:0] e);
      expq.push_back(e);
      op(1'b0, s, 8'h00);
   endtask : rd
   task automatic w16(input logic [7:0] i, input logic [15:0] v);
      op(1'b1, SEL_INDEX, i);
      op(1'b1, SEL_DATA_HIGH, v[15:8]);
      op(1'b1, SEL_DATA_LOW, v[7:0]);
   endtask : w16
   task automatic r16(input logic [7:0] i, input logic [15:0] e);
      op(1'b1, SEL_INDEX, i);
      rd(SEL_DATA_HIGH, e[15:8]);
      rd(SEL_DATA_LOW, e[7:0]);
   endtask : r16
   task automatic hold(input int n);
      @(posedge sys_clk_i);
      acc <= '0;
      repeat (n) @(posedge sys_clk_i);
   endtask : hold
   task automatic meet(input logic want_smp, output int at);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (((want_smp ? smp : bst) !== 1'b1) && n < 3000);
      if ((want_smp ? smp : bst) !== 1'b1) fails++;
      at = cyc;
   endtask : meet
   // ----------------------------------------------------------------
   // clock, watcher, watchdog, sequence
   // ----------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      rd_pend <= acc.rd;
   end
   always @(negedge sys_clk_i) begin
      if (rd_pend) chk("rdata", {8'h00, expq.pop_front()}, {8'h00, rdata});
   end
   initial begin
      #100us;
      fails++;
      stop_test();
   end
   initial begin
      logic [15:0] v;
      seed = 32'h18D84F2B;
      rst_i = 1'b1;
      acc = '0;
      edge_req = 1'b0;
      flags = '0;
      cyc = 0;
      fails = 0;
      total_checks = 0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(SEL_CONTROL, CONTROL_RESET[7:0]);
      r16(IDX_BIT_TIMING, TIMING_RESET);
      r16(IDX_PRESCALER, PRESC_RESET);
      w16(IDX_BIT_TIMING, 16'h5EC0);
      r16(IDX_BIT_TIMING, TIMING_RESET);
      op(1'b1, SEL_CONTROL, 8'h41);
      r16(IDX_CONTROL, 16'h0041);
      rd(SEL_STATUS, 8'h00);
      op(1'b1, SEL_TEST, 8'h5A);
      r16(IDX_TEST, 16'h005A);
      w16(IDX_BIT_TIMING, 16'h5EC0);
      r16(IDX_BIT_TIMING, 16'h5EC0);
      seed = xs(seed);
      v = {12'h000, seed[3:0] | 4'h1};
      w16(IDX_PRESCALER, v);
      r16(IDX_PRESCALER, PRESC_RESET);
      op(1'b1, SEL_CONTROL, 8'hC1);
      w16(IDX_PRESCALER, v);
      r16(IDX_PRESCALER, v);
      w16(IDX_PRESCALER, PRESC_RESET);
      for (int k = 0; k < 2; k++) begin
         v[7:0] = k ? IDX_SET2_LAST : IDX_SET1_LAST;
         op(1'b1, SEL_INDEX, v[7:0] - 8'h01);
         op(1'b1, SEL_DATA_LOW, 8'h00);
         rd(SEL_INDEX, v[7:0]);
         op(1'b1, SEL_DATA_LOW, 8'h00);
         rd(SEL_INDEX, v[7:0]);
      end
      seed = xs(seed);
      flags <= {xs(seed), seed, ~seed};
      op(1'b1, SEL_INDEX, IDX_TXREQ_1);
      rd(SEL_INDEX, IDX_TXREQ_1);
      for (int k = 0; k < 6; k++) begin
         v = 16'(flags >> SHIFT[k]);
         w16(HIDX[k], ~v);
         r16(HIDX[k], v);
      end
      r16(IDX_MSGVAL_1, 16'h0000);
      seed = xs(seed);
      w16(IDX_SET1_FIRST + 8'h01, 16'h00FF);
      w16(8'h0F, seed[15:0]);
      w16(IDX_SET1_FIRST + 8'h06, 16'h8000);
      w16(IDX_SET1_FIRST, 16'h0005);
      // a transfer is one clock; the pause only spaces the two sets
      hold(32);
      r16(IDX_MSGVAL_1, 16'h0010);
      w16(IDX_SET2_FIRST + 8'h01, 16'h007F);
      w16(IDX_SET2_FIRST, 16'h0005);
      hold(32);
      r16(IDX_SET2_FIRST + 8'h07, seed[15:0]);
      for (int b = 0; b < 2; b++) begin
         op(1'b1, SEL_CONTROL, 8'h41);
         w16(IDX_BIT_TIMING, 16'h5EC0 | 16'(b));
         op(1'b1, SEL_CONTROL, 8'h00);
         hold(0);
         meet(1'b0, t0);
         chk("in_init", 16'h0000, {15'h0000, in_init});
         meet(1'b1, t1);
         meet(1'b0, t2);
         chk("bit_period", 16'(22 * (b + 1)), 16'(t2 - t0));
         chk("phase2", 16'(6 * (b + 1)), 16'(t2 - t1));
      end
      @(posedge sys_clk_i);
      edge_req <= 1'b1;
      @(posedge sys_clk_i);
      edge_req <= 1'b0;
      // edge lands on the first prop quantum: bit stretches by one quantum
      meet(1'b0, t0);
      chk("resync_bit", 16'h002E, 16'(t0 - t2));
      hold(100);
      stop_test();
   end
endmodule : tb
bind cbtr_core cbtr_monitor u_cbtr_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .acc_i(acc_i),
   .edge_i(edge_i), .rdata_o(rdata_o), .in_init_o(in_init_o), .sample_o(sample_o),
   .bit_start_o(bit_start_o));
`default_nettype wire
